// [rtl/io_access_decode.v]
// access decode: ownership by identifier, key check and range check
// assumes access fields are registered in the same clock domain
`timescale 1ns/10ps
`include "io_unit_consts.vh"

module io_access_decode #(
	parameter ID_W = 9
) (
	input wire direct_in,
	input wire key_sup_in,
	input wire key_prob_in,
	input wire prob_state_in,
	input wire [ID_W-1:0] id_in,
	input wire [31:0] addr_in,
	input wire [ID_W-1:0] my_id_in,
	input wire [31:0] ctrl_in,
	input wire [31:0] mem_base_in,
	input wire [31:0] mem_mask_in,
	output wire claim_out,
	output wire ds_hit_out,
	output wire mem_hit_out,
	output wire key_fault_out,
	output wire range_fault_out
);
	wire key_sel;

	// direct-store: all identifier bits must match our own
	assign ds_hit_out = ctrl_in[`CTRL_DS_EN] & direct_in & (id_in == my_id_in);
	// ordinary segment: a plain memory window, no key checking here
	assign mem_hit_out = ctrl_in[`CTRL_MEM_EN] & ~direct_in & ((addr_in & mem_mask_in) == mem_base_in);
	assign claim_out = ds_hit_out | mem_hit_out;
	// the key that applies follows the processor state of the access
	assign key_sel = prob_state_in ? key_prob_in : key_sup_in;
	assign key_fault_out = ds_hit_out & ctrl_in[`CTRL_KEY_EN] & key_sel;
	// own extra check: offsets outside the local window fault as well
	assign range_fault_out = ds_hit_out & ctrl_in[`CTRL_RANGE_EN] & ((addr_in & `DS_WINDOW_MASK) != 32'h0000_0000);
endmodule

// [rtl/io_reg_bank.v]
// local register bank reached by claimed loads and stores
// assumes writes are already gated by the fault decision
`timescale 1ns/10ps
`include "io_unit_consts.vh"

module io_reg_bank #(
	parameter DEPTH = 16
) (
	input wire ref_clk_in,
	input wire rst_in,
	input wire wr_in,
	input wire [3:0] idx_in,
	input wire [31:0] wdata_in,
	output wire [31:0] rdata_out
);
	reg [31:0] mem_reg [0:DEPTH-1];
	integer i;

	// write only on an accepted store; faulted stores never get here
	always @(posedge ref_clk_in) begin
		if (rst_in) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				mem_reg[i] <= 32'h0000_0000;
			end
		end else if (wr_in) begin
			mem_reg[idx_in] <= wdata_in;
		end
	end

	assign rdata_out = mem_reg[idx_in];
endmodule

// [rtl/io_unit_consts.vh]
// constants for the io unit address decode and protection block
// included by the decode, the register bank and the top module
`ifndef IO_UNIT_CONSTS_VH
`define IO_UNIT_CONSTS_VH

// apb register byte offsets
`define OFF_CTRL 12'h000
`define OFF_IDENT 12'h004
`define OFF_STATUS 12'h008
`define OFF_FAULT_ADDR 12'h00c
`define OFF_SEG_DESC 12'h010
`define OFF_MEM_BASE 12'h014
`define OFF_MEM_MASK 12'h018
`define OFF_SCRATCH 12'h01c

// control register fields
`define CTRL_DS_EN 0
`define CTRL_MEM_EN 1
`define CTRL_KEY_EN 2
`define CTRL_RANGE_EN 3
`define CTRL_RESET 32'h0000_0005

// status register fields
`define ST_FAULT 0
`define ST_CHECKSTOP 1
`define ST_DS_HIT 2
`define ST_MEM_HIT 3

// segment descriptor fields, bit 0 is the msb
`define SEG_DIRECT 31
`define SEG_KEY_SUP 30
`define SEG_KEY_PROB 29
`define SEG_ID_HI 28
`define SEG_ID_LO 20

// answer codes on the response channel
`define RESP_OK 2'b00
`define RESP_FAULT_INVALID 2'b01
`define RESP_CHECKSTOP 2'b11

// read data returned on a faulted load
`define SAFE_LOAD_DATA 32'h0000_0000

// local window inside a direct-store segment; offsets outside it fault when the range check is on
`define DS_WINDOW_MASK 32'h0fff_f000

`endif

// [rtl/io_unit_protect.v]
// io unit controller: address decode, key protection, fault answer
// assumes access channel signals are synchronous to ref_clk_in, one-cycle request
//
// Implementation choices: the APB interface to the registers and the register offsets.
`timescale 1ns/10ps
`include "io_unit_consts.vh"

// Overview of operation
// - ordinary-segment accesses decode as a plain memory window and answer like memory.
// - store data is used only once the access is accepted and checks pass.
// - a corrupted store escalates to a sticky checkstop that blocks further writes.
// - direct-store accesses are selected by bus unit identifier, disjoint from memory.
// - direct-store loads and stores are never cached; each reaches the unit.
// - the segment descriptor register reads back exactly what was last written.
// - facilities are open only when the applicable key bit is zero.
// - key bit one gives a data storage fault with invalid-operation status.
// - all nine identifier bits are compared to claim the access.
// - an optional offset range check adds to the key check.
// - the full nine-bit identifier must equal ident_reg to claim the access.
// - every claimed load returns data with good parity, safe data on fault.
module io_unit_protect #(
	parameter ID_W = 9,
	parameter [ID_W-1:0] ID_RESET = 9'h001 // arbitrary default identifier
) (
	input wire ref_clk_in,
	input wire rst_in,
	// apb slave
	input wire psel_in,
	input wire penable_in,
	input wire pwrite_in,
	input wire [11:0] paddr_in,
	input wire [31:0] pwdata_in,
	output reg [31:0] prdata_out,
	output reg pready_out,
	output reg pslverr_out,
	// access channel from the interconnect
	input wire acc_valid_in,
	input wire acc_write_in,
	input wire acc_direct_in,
	input wire acc_key_sup_in,
	input wire acc_key_prob_in,
	input wire acc_prob_state_in,
	input wire [ID_W-1:0] acc_id_in,
	input wire [31:0] acc_addr_in,
	input wire [31:0] acc_wdata_in,
	input wire acc_wdata_good_in,
	// answer channel
	output reg resp_valid_out,
	output reg [1:0] resp_code_out,
	output reg [31:0] resp_rdata_out,
	output reg resp_parity_out,
	output reg checkstop_out
);
	reg [31:0] ctrl_reg;
	reg [ID_W-1:0] ident_reg;
	reg [31:0] status_reg;
	reg [31:0] fault_addr_reg;
	reg [31:0] seg_desc_reg;
	reg [31:0] mem_base_reg;
	reg [31:0] mem_mask_reg;
	reg [31:0] scratch_reg;
	reg [31:0] rd_next;
	reg known_next;
	wire claim;
	wire ds_hit;
	wire mem_hit;
	wire key_fault;
	wire range_fault;
	wire reject;
	wire corrupt;
	wire bank_wr;
	wire [31:0] bank_rdata;
	wire [31:0] seg_view;

	// odd parity over a data word, used for every load answer
	function parity_of;
		input [31:0] d;
		begin
			parity_of = ~(^d);
		end
	endfunction

	// apb decode on the word offset
	function is_reg;
		input [11:0] a;
		input [11:0] off;
		begin
			is_reg = (a == off);
		end
	endfunction

	io_access_decode #(.ID_W(ID_W)) u_decode (
		.direct_in(acc_direct_in),
		.key_sup_in(acc_key_sup_in),
		.key_prob_in(acc_key_prob_in),
		.prob_state_in(acc_prob_state_in),
		.id_in(acc_id_in),
		.addr_in(acc_addr_in),
		.my_id_in(ident_reg),
		.ctrl_in(ctrl_reg),
		.mem_base_in(mem_base_reg),
		.mem_mask_in(mem_mask_reg),
		.claim_out(claim),
		.ds_hit_out(ds_hit),
		.mem_hit_out(mem_hit),
		.key_fault_out(key_fault),
		.range_fault_out(range_fault)
	);

	// a write that fails its key or range check, or arrives corrupt, is dropped
	assign reject = key_fault | range_fault;
	assign corrupt = acc_write_in & ~acc_wdata_good_in;
	assign bank_wr = acc_valid_in & claim & acc_write_in & ~reject & ~corrupt & ~checkstop_out;

	io_reg_bank #(.DEPTH(16)) u_bank (
		.ref_clk_in(ref_clk_in),
		.rst_in(rst_in),
		.wr_in(bank_wr),
		.idx_in(acc_addr_in[5:2]),
		.wdata_in(acc_wdata_in),
		.rdata_out(bank_rdata)
	);

	// descriptor: the whole word reads back exactly as last written, flags included
	assign seg_view = seg_desc_reg;

	// access channel answer: one cycle after every claimed request, uncached each time
	always @(posedge ref_clk_in) begin
		if (rst_in) begin
			resp_valid_out <= 1'b0;
			resp_code_out <= `RESP_OK;
			resp_rdata_out <= 32'h0000_0000;
			resp_parity_out <= 1'b1;
			checkstop_out <= 1'b0;
		end else begin
			resp_valid_out <= acc_valid_in & claim;
			if (acc_valid_in & claim) begin
				if (checkstop_out | corrupt) begin
					resp_code_out <= `RESP_CHECKSTOP;
					resp_rdata_out <= `SAFE_LOAD_DATA;
					resp_parity_out <= parity_of(`SAFE_LOAD_DATA);
				end else if (reject) begin
					resp_code_out <= `RESP_FAULT_INVALID;
					resp_rdata_out <= `SAFE_LOAD_DATA;
					resp_parity_out <= parity_of(`SAFE_LOAD_DATA);
				end else begin
					resp_code_out <= `RESP_OK;
					resp_rdata_out <= acc_write_in ? 32'h0000_0000 : bank_rdata;
					resp_parity_out <= parity_of(acc_write_in ? 32'h0000_0000 : bank_rdata);
				end
			end
			// corrupt store data must not propagate: stop until reset
			if (acc_valid_in & claim & corrupt) begin
				checkstop_out <= 1'b1;
			end
		end
	end

	// apb slave: zero wait state, pready in the access phase
	always @(posedge ref_clk_in) begin
		if (rst_in) begin
			pready_out <= 1'b0;
			pslverr_out <= 1'b0;
		end else begin
			pready_out <= psel_in & ~penable_in;
			pslverr_out <= psel_in & ~penable_in & ~(paddr_in[11:5] == 7'h00);
		end
	end

	// register writes take effect at the access edge; status is sticky, write one clears
	always @(posedge ref_clk_in) begin
		if (rst_in) begin
			ctrl_reg <= `CTRL_RESET;
			ident_reg <= ID_RESET;
			status_reg <= 32'h0000_0000;
			fault_addr_reg <= 32'h0000_0000;
			seg_desc_reg <= 32'h0000_0000;
			mem_base_reg <= 32'h0000_0000;
			mem_mask_reg <= 32'h0000_0000;
			scratch_reg <= 32'h0000_0000;
		end else begin
			if (psel_in & penable_in & pready_out & pwrite_in) begin
				if (is_reg(paddr_in, `OFF_CTRL)) begin
					ctrl_reg <= pwdata_in;
				end
				if (is_reg(paddr_in, `OFF_IDENT)) begin
					ident_reg <= pwdata_in[ID_W-1:0];
				end
				if (is_reg(paddr_in, `OFF_SEG_DESC)) begin
					seg_desc_reg <= pwdata_in;
				end
				if (is_reg(paddr_in, `OFF_MEM_BASE)) begin
					mem_base_reg <= pwdata_in;
				end
				if (is_reg(paddr_in, `OFF_MEM_MASK)) begin
					mem_mask_reg <= pwdata_in;
				end
				if (is_reg(paddr_in, `OFF_SCRATCH)) begin
					scratch_reg <= pwdata_in;
				end
				if (is_reg(paddr_in, `OFF_STATUS)) begin
					status_reg <= status_reg & ~pwdata_in;
				end
			end
			// hardware set after the clear so a same-cycle event wins
			if (acc_valid_in & claim & reject) begin
				status_reg[`ST_FAULT] <= 1'b1;
				fault_addr_reg <= acc_addr_in;
			end
			if (acc_valid_in & claim & corrupt) begin
				status_reg[`ST_CHECKSTOP] <= 1'b1;
			end
			if (acc_valid_in & ds_hit) begin
				status_reg[`ST_DS_HIT] <= 1'b1;
			end
			if (acc_valid_in & mem_hit) begin
				status_reg[`ST_MEM_HIT] <= 1'b1;
			end
		end
	end

	// apb read mux; unmapped words read zero with pslverr
	always @* begin
		rd_next = 32'h0000_0000;
		known_next = 1'b1;
		case (paddr_in)
			`OFF_CTRL: rd_next = ctrl_reg;
			`OFF_IDENT: rd_next = {{(32-ID_W){1'b0}}, ident_reg};
			`OFF_STATUS: rd_next = status_reg;
			`OFF_FAULT_ADDR: rd_next = fault_addr_reg;
			`OFF_SEG_DESC: rd_next = seg_view;
			`OFF_MEM_BASE: rd_next = mem_base_reg;
			`OFF_MEM_MASK: rd_next = mem_mask_reg;
			`OFF_SCRATCH: rd_next = scratch_reg;
			default: known_next = 1'b0;
		endcase
	end

	// read data is captured in the setup cycle so it is valid with pready
	always @(posedge ref_clk_in) begin
		if (rst_in) begin
			prdata_out <= 32'h0000_0000;
		end else if (psel_in & ~penable_in & ~pwrite_in) begin
			prdata_out <= known_next ? rd_next : 32'h0000_0000;
		end
	end
endmodule

// [verification/io_proc_model.sv]
// processor model: forms io accesses from a segment descriptor
// seg_in uses bit 31 as descriptor bit 0; tb calls issue()
`timescale 1ns/10ps
module io_proc_model #(parameter ID_W = 9) (
	input logic ref_clk_in,
	input logic [31:0] seg_in,
	output logic acc_valid_out,
	output logic acc_write_out,
	output logic acc_direct_out,
	output logic acc_key_sup_out,
	output logic acc_key_prob_out,
	output logic acc_prob_state_out,
	output logic [ID_W-1:0] acc_id_out,
	output logic [31:0] acc_addr_out,
	output logic [31:0] acc_wdata_out,
	output logic acc_wdata_good_out
);
	initial begin
		{acc_valid_out, acc_write_out, acc_direct_out, acc_key_sup_out} = 4'h0;
		{acc_key_prob_out, acc_prob_state_out, acc_wdata_good_out} = 3'h0;
		acc_id_out = '0;
		acc_addr_out = 32'h0000_0000;
		acc_wdata_out = 32'h0000_0000;
	end
	// one-cycle request; address and write data flip afterwards so stale values never match
	task issue(input logic w, input logic ps, input logic [31:0] ea, input logic [31:0] wd, input logic good);
		@(posedge ref_clk_in);
		acc_valid_out <= 1'b1;
		acc_write_out <= w;
		acc_prob_state_out <= ps;
		acc_direct_out <= seg_in[31];
		acc_key_sup_out <= seg_in[30];
		acc_key_prob_out <= seg_in[29];
		acc_id_out <= seg_in[28:28-ID_W+1];
		acc_addr_out <= seg_in[31] ? {seg_in[3:0], ea[27:0]} : ea;
		acc_wdata_out <= wd;
		acc_wdata_good_out <= good;
		@(posedge ref_clk_in);
		acc_valid_out <= 1'b0;
		acc_addr_out <= ~acc_addr_out;
		acc_wdata_out <= ~acc_wdata_out;
	endtask
endmodule

// [verification/io_unit_chk.sv]
// checker for claim, key fault and fault answers of the io unit
// bound to io_unit_protect, sees its ports only
`timescale 1ns/10ps
module io_unit_chk #(
	parameter ID_W = 9,
	parameter [ID_W-1:0] ID_RESET = 9'h001 // arbitrary default identifier
) (
	input logic ref_clk_in,
	input logic rst_in,
	input logic psel_in,
	input logic penable_in,
	input logic pwrite_in,
	input logic [11:0] paddr_in,
	input logic [31:0] pwdata_in,
	input logic pready_out,
	input logic acc_valid_in,
	input logic acc_write_in,
	input logic acc_direct_in,
	input logic acc_key_sup_in,
	input logic acc_key_prob_in,
	input logic acc_prob_state_in,
	input logic [ID_W-1:0] acc_id_in,
	input logic acc_wdata_good_in,
	input logic resp_valid_out,
	input logic [1:0] resp_code_out,
	input logic [31:0] resp_rdata_out,
	input logic resp_parity_out,
	input logic checkstop_out
);
	logic [31:0] ctrl_reg;
	logic [ID_W-1:0] id_reg;
	logic key_sel, claim, clean;
	// shadow of ctrl and ident, since the bank itself is hidden
	always @(posedge ref_clk_in) begin
		if (rst_in) begin
			ctrl_reg <= 32'h0000_0005;
			id_reg <= ID_RESET;
		end else if (psel_in && penable_in && pready_out && pwrite_in) begin
			if (paddr_in == 12'h000) ctrl_reg <= pwdata_in;
			if (paddr_in == 12'h004) id_reg <= pwdata_in[ID_W-1:0];
		end
	end
	assign key_sel = acc_prob_state_in ? acc_key_prob_in : acc_key_sup_in;
	assign claim = acc_valid_in && acc_direct_in && ctrl_reg[0] && acc_id_in == id_reg;
	// store data trouble or checkstop take over the answer code
	assign clean = !checkstop_out && (!acc_write_in || acc_wdata_good_in);
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (rst_in);
	sequence s_apb_setup;
		psel_in && !penable_in ##1 psel_in && penable_in;
	endsequence
	sequence s_bad_store;
		claim && acc_write_in && !acc_wdata_good_in ##1 resp_valid_out;
	endsequence
	a_apb_ready_now: assert property (s_apb_setup |-> pready_out)
		else $error("apb access phase without ready");
	a_claim_answers: assert property (claim |=> resp_valid_out)
		else $error("claimed access got no answer");
	a_foreign_silent: assert property (acc_valid_in && acc_direct_in && acc_id_in != id_reg |=> !resp_valid_out)
		else $error("foreign identifier answered");
	a_key_fault: assert property (claim && ctrl_reg[2] && key_sel && clean |=> resp_code_out == 2'b01)
		else $error("key one not faulted");
	a_key_open: assert property (claim && !key_sel && !ctrl_reg[3] && clean |=> resp_code_out == 2'b00)
		else $error("key zero refused");
	a_fault_data: assert property (resp_valid_out && resp_code_out != 2'b00 |-> resp_rdata_out == 32'h0000_0000)
		else $error("faulted answer carries data");
	a_load_parity: assert property (resp_valid_out |-> resp_parity_out == ~^resp_rdata_out)
		else $error("answer parity bad");
	a_stop_sticky: assert property (checkstop_out |=> checkstop_out)
		else $error("checkstop dropped");
	a_bad_store: assert property (s_bad_store |-> resp_code_out == 2'b11 ##[0:1] checkstop_out)
		else $error("bad store data used");
endmodule

// [verification/test_io_unit_protect.sv]
// self-checking bench for io_unit_protect
// apb master here, processor model drives the access channel
`timescale 1ns/10ps
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin fails++; $display("BAD %0t %h %h", $time, a, b); end end
bind io_unit_protect io_unit_chk #(.ID_W(ID_W), .ID_RESET(ID_RESET)) chk (
	.ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
	.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .pready_out(pready_out),
	.acc_valid_in(acc_valid_in), .acc_write_in(acc_write_in), .acc_direct_in(acc_direct_in),
	.acc_key_sup_in(acc_key_sup_in), .acc_key_prob_in(acc_key_prob_in),
	.acc_prob_state_in(acc_prob_state_in), .acc_id_in(acc_id_in), .acc_wdata_good_in(acc_wdata_good_in),
	.resp_valid_out(resp_valid_out), .resp_code_out(resp_code_out), .resp_rdata_out(resp_rdata_out),
	.resp_parity_out(resp_parity_out), .checkstop_out(checkstop_out));
module test_io_unit_protect;
	logic ref_clk_in, rst_in, psel_in, penable_in, pwrite_in;
	logic [11:0] paddr_in;
	logic [31:0] pwdata_in, prdata_out, resp_rdata_out, acc_addr_in, acc_wdata_in, seg, ar, rd;
	logic pready_out, pslverr_out, resp_valid_out, resp_parity_out, checkstop_out, ae, rv;
	logic acc_valid_in, acc_write_in, acc_direct_in, acc_key_sup_in, acc_key_prob_in;
	logic acc_prob_state_in, acc_wdata_good_in;
	logic [8:0] acc_id_in;
	logic [1:0] resp_code_out, rc;
	int fails = 0;
	int cmp_count = 0;
	io_unit_protect DUT (
		.ref_clk_in(ref_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
		.pwrite_in(pwrite_in), .paddr_in(paddr_in), .pwdata_in(pwdata_in), .prdata_out(prdata_out),
		.pready_out(pready_out), .pslverr_out(pslverr_out), .acc_valid_in(acc_valid_in),
		.acc_write_in(acc_write_in), .acc_direct_in(acc_direct_in), .acc_key_sup_in(acc_key_sup_in),
		.acc_key_prob_in(acc_key_prob_in), .acc_prob_state_in(acc_prob_state_in), .acc_id_in(acc_id_in),
		.acc_addr_in(acc_addr_in), .acc_wdata_in(acc_wdata_in), .acc_wdata_good_in(acc_wdata_good_in),
		.resp_valid_out(resp_valid_out), .resp_code_out(resp_code_out), .resp_rdata_out(resp_rdata_out),
		.resp_parity_out(resp_parity_out), .checkstop_out(checkstop_out));
	io_proc_model m (.ref_clk_in(ref_clk_in), .seg_in(seg), .acc_valid_out(acc_valid_in),
		.acc_write_out(acc_write_in), .acc_direct_out(acc_direct_in), .acc_key_sup_out(acc_key_sup_in),
		.acc_key_prob_out(acc_key_prob_in), .acc_prob_state_out(acc_prob_state_in),
		.acc_id_out(acc_id_in), .acc_addr_out(acc_addr_in), .acc_wdata_out(acc_wdata_in),
		.acc_wdata_good_out(acc_wdata_good_in));
	initial begin
		ref_clk_in = 0;
		forever #2.5 ref_clk_in = ~ref_clk_in;
	end
	// apb transfer; holds the request until ready is seen, only the watchdog ends a hung wait
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk_in);
		{psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} <= {2'b10, w, a, d};
		@(posedge ref_clk_in);
		penable_in <= 1'b1;
		do begin @(posedge ref_clk_in); end while (pready_out !== 1'b1);
		ar = prdata_out;
		ae = pslverr_out;
		psel_in <= 1'b0;
		penable_in <= 1'b0;
	endtask
	task acc(input logic w, input logic ps, input logic [31:0] ea, input logic [31:0] wd, input logic good);
		m.issue(w, ps, ea, wd, good);
		#1;
		{rv, rc, rd} = {resp_valid_out, resp_code_out, resp_rdata_out};
	endtask
	task t_regs;
		apb(0, 12'h000, 0); `CHK(ar, 32'h0000_0005)
		apb(0, 12'h004, 0); `CHK(ar, 32'h0000_0001)
		apb(1, 12'h020, 32'h1111_1111); `CHK(ae, 1'b1)
		apb(0, 12'h020, 0); `CHK(ar, 32'h0000_0000)
		apb(1, 12'h010, 32'ha5c3_0f96);
		apb(0, 12'h010, 0); `CHK(ar, 32'ha5c3_0f96)
		$display("t_regs done");
	endtask
	task t_direct;
		seg = {3'b100, 9'h001, 16'h0000, 4'h3};
		acc(1, 0, 32'h0000_0008, 32'h1234_5678, 1); `CHK({rv, rc}, 3'b100)
		acc(0, 1, 32'h0000_0008, 0, 1); `CHK(rd, 32'h1234_5678)
		acc(0, 0, 32'h0000_0008, 0, 1); `CHK(rd, 32'h1234_5678)
		$display("t_direct done");
	endtask
	task t_key;
		seg = {3'b110, 9'h001, 20'h00000};
		acc(1, 0, 32'h0000_0008, 32'hffff_0000, 1); `CHK({rc, rd}, {2'b01, 32'h0})
		acc(1, 1, 32'h0000_0008, 32'hffff_0000, 1); `CHK(rc, 2'b00)
		seg = {3'b101, 9'h001, 20'h00000};
		acc(1, 1, 32'h0000_0008, 32'h0bad_0bad, 1); `CHK(rc, 2'b01)
		acc(0, 0, 32'h0000_0008, 0, 1); `CHK(rd, 32'hffff_0000)
		apb(0, 12'h008, 0); `CHK(ar[0], 1'b1)
		apb(0, 12'h00c, 0); `CHK(ar, 32'h0000_0008)
		apb(1, 12'h008, 32'h0000_0001);
		apb(0, 12'h008, 0); `CHK(ar[0], 1'b0)
		apb(1, 12'h000, 32'h0000_000d);
		acc(0, 0, 32'h0000_1000, 0, 1); `CHK({rv, rc}, 3'b101)
		apb(1, 12'h000, 32'h0000_0005);
		$display("t_key done");
	endtask
	task t_foreign;
		seg = {3'b100, 9'h101, 20'h00000};
		acc(0, 0, 32'h0000_0008, 0, 1); `CHK(rv, 1'b0)
		seg = {3'b100, 9'h003, 20'h00000};
		acc(1, 0, 32'h0000_0008, 32'h0, 1); `CHK(rv, 1'b0)
		$display("t_foreign done");
	endtask
	task t_ordinary;
		apb(1, 12'h018, 32'hffff_ff00);
		apb(1, 12'h014, 32'h8000_0000);
		apb(1, 12'h000, 32'h0000_0007);
		seg = {3'b011, 9'h001, 20'h00000};
		acc(1, 0, 32'h8000_0010, 32'hcafe_0001, 1); `CHK({rv, rc}, 3'b100)
		acc(0, 1, 32'h8000_0010, 0, 1); `CHK(rd, 32'hcafe_0001)
		acc(0, 0, 32'h9000_0010, 0, 1); `CHK(rv, 1'b0)
		$display("t_ordinary done");
	endtask
	task t_stop;
		seg = {3'b100, 9'h001, 20'h00000};
		acc(1, 0, 32'h0000_0008, 32'h5555_aaaa, 0); `CHK({rc, checkstop_out}, 3'b111)
		acc(0, 0, 32'h0000_0008, 0, 1); `CHK({rc, rd}, {2'b11, 32'h0})
		$display("t_stop done");
	endtask
	task stop_test;
		$display("compares %0d mismatches %0d", cmp_count, fails);
		if (fails == 0 && cmp_count > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// watchdog well beyond the hundred or so cycles the tests need
	initial begin
		#20000;
		fails++;
		stop_test;
	end
	initial begin
		{rst_in, psel_in, penable_in, pwrite_in, paddr_in, pwdata_in} = {4'h8, 12'h000, 32'h0};
		seg = 32'h0000_0000;
		repeat (20) @(posedge ref_clk_in);
		rst_in <= 1'b0;
		t_regs;
		t_direct;
		t_key;
		t_foreign;
		t_ordinary;
		t_stop;
		stop_test;
	end
endmodule
